//--- logic/slfs_pkg.sv
/*
  Package for the startup lockout and fault supervisor: register map,
  field positions, reset values, timing counts and shared types.
  Assumes a 25 MHz mclk and a 32-bit Avalon-MM register port.
*/
package slfs_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int SYNC_LOW_NS = 500;
  localparam int SHARE_PERIOD_NS = 10000;
  localparam int SHARE_LOW_NS = 1000;
  localparam int SYNC_LOW_CYC = (SYNC_LOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int SHARE_PERIOD_CYC = (SHARE_PERIOD_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int SHARE_LOW_CYC = (SHARE_LOW_NS * (CLK_HZ / 1000000) + 999) / 1000;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, word aligned)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FAULT_CFG = 8'h08;
  localparam logic [7:0] REG_RESPONSE = 8'h0c;
  localparam logic [7:0] REG_RETRY = 8'h10;
  localparam logic [7:0] REG_PEAK = 8'h14;
  localparam logic [7:0] REG_LOG = 8'h18;
  localparam logic [7:0] REG_BUS_CMD = 8'h1c;
  localparam logic [7:0] REG_ADDR = 8'h20;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_LOG_EN = 0;
  localparam int CTRL_SYNC_EN = 1;
  localparam int CTRL_ALERT_EXT_MASK = 2;
  localparam int CTRL_CML_CLR = 3;
  localparam int COMMON_NVM_UNINIT = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0003;
  localparam logic [15:0] RETRY_RST = 16'h0400;
  localparam logic [6:0] ADDR_RST = 7'h40;
  localparam logic [7:0] TEMP_WARN_C = 8'h55;
  localparam logic [7:0] TEMP_OFF_C = 8'h82;
  localparam logic [7:0] TEMP_ON_C = 8'h78;

  // ----------------------------------------------------------------
  // bus unlock sequence
  // ----------------------------------------------------------------
  localparam logic [6:0] GLOBAL_ADDR_A = 7'h5a;
  localparam logic [6:0] GLOBAL_ADDR_B = 7'h5b;
  localparam logic [7:0] UNLOCK_CMD = 8'hbd;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h2b;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hc4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    slfs_resp_ignore = 2'h0,
    slfs_resp_latch = 2'h1,
    slfs_resp_retry = 2'h2
  } slfs_resp_t;

  typedef enum logic [4:0] {
    slfs_st_reset = 5'h01,
    slfs_st_vin_low = 5'h02,
    slfs_st_run = 5'h04,
    slfs_st_latched = 5'h08,
    slfs_st_retry = 5'h10
  } slfs_state_t;

  typedef struct packed {
    logic ov;
    logic uv;
    logic oc;
    logic ot;
    logic timing;
    logic peak_oc;
  } slfs_faults_t;

  typedef struct packed {
    logic vin_ok;
    logic input_turn_on_threshold;
    logic input_turn_off_threshold;
    logic rails_20;
    logic dig_7;
  } slfs_supply_t;

  typedef struct packed {
    logic valid;
    logic partial;
    logic [6:0] addr;
    logic [7:0] cmd;
    logic [7:0] data;
  } slfs_pmbus_t;

  typedef struct packed {
    logic top;
    logic bottom;
  } slfs_gate_t;
endpackage

//--- logic/slfs_supervisor.sv
/*
  Startup lockout and fault supervisor top module.
  Assumes synchronous supply comparator levels, decoded PMBus frames
  from an external serial engine, and open-drain pads resolved outside.
*/
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps

// Summary of operation
// R1: no sequencing before input passes turn-on threshold
// R2: below turn-off, hold timebase low until turn-on
// R3: init needs 20% rails; run held until 7%
// R4: fault line low at power-in forces alert
// R5: partial or bad bus command raises alert; only a partial frame sets the alert here
// R6: digital-only supply runs logic, power stays off
// R7: never-powered flag reads low in common bit 3
// R8: uninitialised part answers only 5A and 5B
// R9: two-write BD unlock restores configured address
// R10: after first input, restart command before switching
// R11: fault line selectable per fault, senses external pulls
// R12: response is ignore, latch off, or retry
// R13: overvoltage forces top low, bottom on
// R14: enabled logging captures data on fault shutdown
// R15: peak values readable at any time
// R16: host avoids memory writes above 85C
// R17: memory off above 130C, back below 120C
// R18: sync pulled low 500ns each period
// R19: timebase 10us period, 1us low
// R20: shared lines driven only low, open drain
// R21: input thresholds form hysteresis, outputs off below
module slfs_supervisor #(
  parameter int SYNC_PERIOD_CYC = 50
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // supply monitors
  input wire slfs_pkg::slfs_supply_t supply,
  input wire logic [7:0] die_temp_c,
  // channel faults and telemetry
  input wire slfs_pkg::slfs_faults_t faults,
  input wire logic [15:0] telemetry,
  // decoded pmbus frames
  input wire slfs_pkg::slfs_pmbus_t pmbus,
  output logic pmbus_ack,
  // gates and enables
  output slfs_pkg::slfs_gate_t gate,
  output logic switch_en,
  output logic nvm_en,
  output logic nvm_warm,
  // open-drain lines: in, out (always 0), enable
  input wire logic fault_line_in,
  output logic fault_line_out,
  output logic fault_line_oe,
  output logic sync_out,
  output logic sync_oe,
  output logic share_clk_out,
  output logic share_clk_oe,
  output logic power_good_out,
  output logic power_good_oe,
  output logic run_out,
  output logic run_oe,
  output logic alert_out,
  output logic alert_oe
);
  import slfs_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [5:0] fault_cfg_q;
  logic [11:0] resp_q;
  logic [15:0] retry_q;
  logic [15:0] peak_q;
  logic [15:0] log_q;
  logic [6:0] addr_q;
  logic ack_q;
  slfs_state_t state_q;
  logic [15:0] retry_cnt_q;
  logic vin_seen_q;
  logic locked_q;
  logic key1_q;
  logic need_restart_q;
  logic cml_q;
  logic ext_alert_q;
  logic hot_q;
  logic [7:0] sync_cnt_q;
  logic [8:0] share_cnt_q;
  logic rd_done_q;
  function automatic logic cmd_match(input slfs_pmbus_t f, input logic [6:0] a, input logic [7:0] c);
    cmd_match = f.valid && !f.partial && f.addr == a && f.cmd == c;
  endfunction

  // ----------------------------------------------------------------
  // bus slave: one wait state on reads
  // ----------------------------------------------------------------
  // read data is registered, so it must stand before the taking edge
  assign avs_waitrequest = avs_read && !rd_done_q;
  logic wr_ctrl, wr_restart;
  assign wr_ctrl = avs_write && avs_address == REG_CTRL;
  assign wr_restart = avs_write && avs_address == REG_BUS_CMD;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      fault_cfg_q <= 6'h3f;
      resp_q <= 12'h000;
      retry_q <= RETRY_RST;
    end else if (avs_write) begin
      unique case (avs_address)
        REG_CTRL: ctrl_q <= avs_writedata;
        REG_FAULT_CFG: fault_cfg_q <= avs_writedata[5:0];
        REG_RESPONSE: resp_q <= avs_writedata[11:0];
        REG_RETRY: retry_q <= avs_writedata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= avs_read && !rd_done_q;
      if (avs_read && !rd_done_q) begin
        unique case (avs_address)
          REG_CTRL: avs_readdata <= ctrl_q;
          REG_STATUS: avs_readdata <= {20'h0, state_q, hot_q, ext_alert_q, cml_q, vin_seen_q, 3'h0}; // R7
          REG_FAULT_CFG: avs_readdata <= {26'h0, fault_cfg_q};
          REG_RESPONSE: avs_readdata <= {20'h0, resp_q};
          REG_RETRY: avs_readdata <= {16'h0, retry_q};
          REG_PEAK: avs_readdata <= {16'h0, peak_q}; // R15
          REG_LOG: avs_readdata <= {16'h0, log_q};
          REG_ADDR: avs_readdata <= {24'h0, locked_q, addr_q};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // supply history and restricted addressing
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      vin_seen_q <= 1'b0;
    end else if (supply.vin_ok) begin
      vin_seen_q <= 1'b1;
    end
  end
  // a host can only unlock through the global address while locked
  always_ff @(posedge mclk) begin
    if (rst) begin
      locked_q <= 1'b1;
      key1_q <= 1'b0;
      addr_q <= ADDR_RST;
    end else begin
      if (avs_write && avs_address == REG_ADDR) begin
        addr_q <= avs_writedata[6:0];
      end
      if (vin_seen_q) begin
        locked_q <= 1'b0;
      end else if (locked_q && cmd_match(pmbus, GLOBAL_ADDR_B, UNLOCK_CMD)) begin
        if (pmbus.data == UNLOCK_KEY1) begin
          key1_q <= 1'b1;
        end else if (key1_q && pmbus.data == UNLOCK_KEY2) begin
          locked_q <= 1'b0; // R9
          key1_q <= 1'b0;
        end else begin
          key1_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else if (locked_q) begin
      ack_q <= pmbus.valid && (pmbus.addr == GLOBAL_ADDR_A || pmbus.addr == GLOBAL_ADDR_B); // R8
    end else begin
      ack_q <= pmbus.valid && pmbus.addr == addr_q; // R6
    end
  end
  assign pmbus_ack = ack_q;

  // restart needed once input first arrives after digital-only setup
  always_ff @(posedge mclk) begin
    if (rst) begin
      need_restart_q <= 1'b0;
    end else if (supply.vin_ok && !vin_seen_q) begin
      need_restart_q <= 1'b1; // R10
    end else if (wr_restart) begin
      need_restart_q <= 1'b0; // R10
    end
  end

  // ----------------------------------------------------------------
  // alert sources: set wins over clear
  // ----------------------------------------------------------------
  logic cml_event;
  assign cml_event = pmbus.valid && pmbus.partial;
  always_ff @(posedge mclk) begin
    if (rst) begin
      cml_q <= 1'b0;
      ext_alert_q <= 1'b0;
    end else begin
      if (cml_event) begin
        cml_q <= 1'b1; // R5
      end else if (wr_ctrl && avs_writedata[CTRL_CML_CLR]) begin
        cml_q <= 1'b0;
      end
      if (supply.vin_ok && !vin_seen_q && !fault_line_in) begin
        ext_alert_q <= 1'b1; // R4
      end else if (wr_ctrl && avs_writedata[CTRL_CML_CLR]) begin
        ext_alert_q <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // temperature lockout of nonvolatile memory
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      hot_q <= 1'b0;
    end else if (die_temp_c > TEMP_OFF_C) begin
      hot_q <= 1'b1; // R17
    end else if (die_temp_c < TEMP_ON_C) begin
      hot_q <= 1'b0; // R17
    end
  end
  assign nvm_en = !hot_q;
  assign nvm_warm = die_temp_c > TEMP_WARN_C; // R16

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  logic any_fault, ext_fault;
  logic [1:0] worst_resp;
  assign ext_fault = !fault_line_in && state_q == slfs_st_run; // R11
  always_comb begin
    any_fault = 1'b0;
    worst_resp = 2'h0;
    for (int i = 0; i < 6; i++) begin
      if (faults[i] && resp_q[2*i +: 2] != 2'h0) begin
        any_fault = 1'b1; // R12
        if (resp_q[2*i +: 2] == slfs_resp_latch) begin
          worst_resp = 2'h1;
        end else if (worst_resp == 2'h0) begin
          worst_resp = resp_q[2*i +: 2];
        end
      end
    end
  end
  logic powered;
  assign powered = supply.rails_20 && supply.vin_ok; // R3

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= slfs_st_reset;
      retry_cnt_q <= 16'h0000;
    end else begin
      unique case (state_q)
        slfs_st_reset: if (powered) state_q <= slfs_st_vin_low;
        slfs_st_vin_low: if (supply.input_turn_on_threshold && !need_restart_q) state_q <= slfs_st_run; // R1
        slfs_st_run: begin
          if (supply.input_turn_off_threshold) begin
            state_q <= slfs_st_vin_low; // R21
          end else if (any_fault) begin
            state_q <= worst_resp == 2'h1 ? slfs_st_latched : slfs_st_retry;
            retry_cnt_q <= retry_q;
          end
        end
        slfs_st_latched: if (supply.input_turn_off_threshold) state_q <= slfs_st_vin_low;
        slfs_st_retry: begin
          if (retry_cnt_q == 16'h0000) begin
            state_q <= slfs_st_vin_low; // R12
          end else begin
            retry_cnt_q <= retry_cnt_q - 16'h0001;
          end
        end
        default: state_q <= slfs_st_reset;
      endcase
    end
  end

  assign switch_en = state_q == slfs_st_run && !need_restart_q; // R10
  assign gate = '{top: switch_en && !faults.ov, bottom: faults.ov}; // R13

  // ----------------------------------------------------------------
  // fault log and peaks
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      peak_q <= 16'h0000;
      log_q <= 16'h0000;
    end else begin
      if (telemetry > peak_q) begin
        peak_q <= telemetry; // R15
      end
      if (ctrl_q[CTRL_LOG_EN] && state_q == slfs_st_run && any_fault) begin
        log_q <= telemetry; // R14
      end
    end
  end

  // ----------------------------------------------------------------
  // sync and timebase pulse generators
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync_cnt_q <= 8'h00;
      share_cnt_q <= 9'h000;
    end else begin
      sync_cnt_q <= sync_cnt_q == 8'(SYNC_PERIOD_CYC - 1) ? 8'h00 : sync_cnt_q + 8'h01;
      share_cnt_q <= share_cnt_q == 9'(SHARE_PERIOD_CYC - 1) ? 9'h000 : share_cnt_q + 9'h001;
    end
  end
  // all shared lines only ever pull low
  assign fault_line_out = 1'b0; // R20
  assign sync_out = 1'b0;
  assign share_clk_out = 1'b0;
  assign power_good_out = 1'b0;
  assign run_out = 1'b0;
  assign alert_out = 1'b0;
  assign fault_line_oe = state_q != slfs_st_run || (|(faults & fault_cfg_q)); // R11
  assign sync_oe = ctrl_q[CTRL_SYNC_EN] && sync_cnt_q < 8'(SYNC_LOW_CYC); // R18
  assign share_clk_oe = state_q != slfs_st_run || share_cnt_q < 9'(SHARE_LOW_CYC); // R2 R19
  assign power_good_oe = state_q != slfs_st_run;
  assign run_oe = !supply.dig_7; // R3
  assign alert_oe = cml_q || ext_alert_q || (ext_fault && !ctrl_q[CTRL_ALERT_EXT_MASK]); // R4 R5
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_ov_gates: assert property (@(posedge mclk) disable iff (rst) faults.ov |-> !gate.top && gate.bottom) // R13
    else $error("overvoltage did not force gates");
  chk_sync_low: assert property (@(posedge mclk) disable iff (rst)
    $rose(sync_oe) |-> sync_oe [*8] ##1 sync_oe [*5] ##1 !sync_oe) // R18
    else $error("sync low pulse wrong length");
  chk_share_low: assert property (@(posedge mclk) disable iff (rst)
    share_cnt_q == 9'h000 && state_q == slfs_st_run |-> share_clk_oe ##25 !share_clk_oe || state_q != slfs_st_run) // R19
    else $error("timebase low pulse wrong length");
  chk_no_early_run: assert property (@(posedge mclk) disable iff (rst)
    $rose(state_q == slfs_st_run) |-> $past(supply.input_turn_on_threshold)) // R1
    else $error("sequencing began below turn-on");
  chk_input_turn_off_threshold: assert property (@(posedge mclk) disable iff (rst)
    state_q == slfs_st_run && supply.input_turn_off_threshold |=> state_q == slfs_st_vin_low ##0 share_clk_oe) // R2
    else $error("turn-off did not stop and hold timebase");
  chk_cml_alert: assert property (@(posedge mclk) disable iff (rst) cml_event |=> alert_oe) // R5
    else $error("partial command did not raise alert");
  chk_locked_addr: assert property (@(posedge mclk) disable iff (rst)
    locked_q && pmbus.valid && pmbus.addr == addr_q && addr_q != GLOBAL_ADDR_A && addr_q != GLOBAL_ADDR_B
    |=> !pmbus_ack) // R8
    else $error("locked part answered own address");
  chk_hot_nvm: assert property (@(posedge mclk) disable iff (rst) die_temp_c > TEMP_OFF_C |=> !nvm_en) // R17
    else $error("memory still enabled when hot");
  chk_restart: assert property (@(posedge mclk) disable iff (rst) need_restart_q |-> !switch_en) // R10
    else $error("switching before restart command");
endmodule

//--- verification/slfs_host_model.sv
/*
  Far-side model: a bus host that sends decoded frames and a peer that
  can pull the shared fault line. Assumes the bench's mclk.
*/
`timescale 1ns/1ps
module slfs_host_model (
  // clock
  input wire logic mclk,
  // frame path
  output slfs_pkg::slfs_pmbus_t pmbus,
  input wire logic pmbus_ack,
  input wire logic nvm_warm,
  // peer pull on the fault line
  output logic peer_fault_pull
);
  import slfs_pkg::*;
  // store command code, value arbitrary
  localparam logic [7:0] STORE_CMD = 8'h15;
  // ------------------------------------------------
  // frame driver
  // ------------------------------------------------
  initial begin
    pmbus = '0;
    peer_fault_pull = 1'b0;
  end
  // one-cycle frame; answer taken the cycle after
  task automatic frame(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, input logic part,
                       output logic ack);
    ack = 1'b0;
    if (nvm_warm === 1'b1 && c == STORE_CMD) begin
      return;
    end
    @(posedge mclk);
    pmbus <= '{valid: 1'b1, partial: part, addr: a, cmd: c, data: d};
    @(posedge mclk);
    // released fields change, so no stale frame can look valid
    pmbus <= '{valid: 1'b0, partial: 1'b0, addr: ~a, cmd: ~c, data: ~d};
    #1;
    ack = pmbus_ack;
  endtask
  task automatic unlock(output logic ack);
    frame(GLOBAL_ADDR_B, UNLOCK_CMD, UNLOCK_KEY1, 1'b0, ack);
    frame(GLOBAL_ADDR_B, UNLOCK_CMD, UNLOCK_KEY2, 1'b0, ack);
  endtask
endmodule

//--- verification/slfs_supervisor_tb_top.sv
/*
  Self-checking bench for the supervisor: register, frame, supply,
  fault and timebase sequences. Assumes the package and host model.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module slfs_supervisor_tb_top;
  import slfs_pkg::*;
  // ------------------------------------------------
  // signals
  // ------------------------------------------------
  logic mclk, rst, avs_read, avs_write, avs_waitrequest, pmbus_ack, switch_en, nvm_en, nvm_warm;
  logic [7:0] avs_address, die_temp_c;
  logic [31:0] avs_writedata, avs_readdata, d;
  slfs_supply_t supply;
  slfs_faults_t faults;
  slfs_pmbus_t pmbus;
  slfs_gate_t gate;
  logic [15:0] telemetry, hs, hy;
  logic fault_line_out, fault_line_oe, sync_out, sync_oe, share_clk_out, share_clk_oe;
  logic power_good_out, power_good_oe, run_out, run_oe, alert_out, alert_oe, peer_pull, ack;
  int n_errors = 0;
  int check_count = 0;
  // pulled-up wire, low if anyone drives
  wire logic fault_line_in = !(fault_line_oe || peer_pull);
  slfs_supervisor #(.SYNC_PERIOD_CYC(50)) slfs_supervisor_i (.mclk(mclk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .supply(supply), .die_temp_c(die_temp_c),
    .faults(faults), .telemetry(telemetry), .pmbus(pmbus), .pmbus_ack(pmbus_ack), .gate(gate),
    .switch_en(switch_en), .nvm_en(nvm_en), .nvm_warm(nvm_warm), .fault_line_in(fault_line_in),
    .fault_line_out(fault_line_out), .fault_line_oe(fault_line_oe), .sync_out(sync_out), .sync_oe(sync_oe),
    .share_clk_out(share_clk_out), .share_clk_oe(share_clk_oe), .power_good_out(power_good_out),
    .power_good_oe(power_good_oe), .run_out(run_out), .run_oe(run_oe), .alert_out(alert_out),
    .alert_oe(alert_oe));
  slfs_host_model slfs_host_model_i (.mclk(mclk), .pmbus(pmbus), .pmbus_ack(pmbus_ack), .nvm_warm(nvm_warm),
    .peer_fault_pull(peer_pull));
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic bus_wait();
    for (int i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) begin
        return;
      end
    end
    n_errors++;
    conclude();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    bus_wait();
    avs_write <= 1'b0;
  endtask
  // read data stands at the edge that samples waitrequest low
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= 1'b1;
    bus_wait();
    v = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic wait_sw(input logic v);
    for (int i = 0; i < 300 && switch_en !== v; i++) begin
      @(posedge mclk);
      #1;
    end
    `CHK(switch_en, v)
    if (switch_en !== v) begin
      conclude();
    end
  endtask
  task automatic count_oe(input int n);
    hs = '0;
    hy = '0;
    repeat (n) begin
      @(posedge mclk);
      #1;
      hs = hs + {15'h0, share_clk_oe};
      hy = hy + {15'h0, sync_oe};
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // ------------------------------------------------
  // clock, watchdog, sequence
  // ------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    supply = '{vin_ok: 1'b0, input_turn_on_threshold: 1'b0, input_turn_off_threshold: 1'b1, rails_20: 1'b1, dig_7: 1'b0};
    die_temp_c = 8'h19;
    faults = '0;
    telemetry = 16'h0abc;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    settle();
    `CHK(run_oe, 1'b1)
    supply.dig_7 <= 1'b1;
    settle();
    `CHK(run_oe, 1'b0)
    rd(REG_CTRL, d);
    `CHK(d, CTRL_RST)
    rd(REG_STATUS, d);
    `CHK(d[COMMON_NVM_UNINIT], 1'b0)
    `CHK(switch_en, 1'b0)
    rd(8'h40, d);
    `CHK(d, 32'h0)
    rd(REG_ADDR, d);
    `CHK(d[7:0], {1'b1, ADDR_RST})
    $display("test reset done");
    slfs_host_model_i.frame(ADDR_RST, 8'h01, 8'h00, 1'b0, ack);
    `CHK(ack, 1'b0)
    slfs_host_model_i.frame(GLOBAL_ADDR_A, 8'h01, 8'h00, 1'b0, ack);
    `CHK(ack, 1'b1)
    slfs_host_model_i.unlock(ack);
    slfs_host_model_i.frame(ADDR_RST, 8'h01, 8'h00, 1'b0, ack);
    `CHK(ack, 1'b1)
    slfs_host_model_i.frame(ADDR_RST, 8'h01, 8'h00, 1'b1, ack);
    settle();
    `CHK(alert_oe, 1'b1)
    wr(REG_CTRL, 32'h0000_000b);
    settle();
    `CHK(alert_oe, 1'b0)
    $display("test bus done");
    slfs_host_model_i.peer_fault_pull <= 1'b1;
    wr(REG_CTRL, 32'h0000_0007);
    supply <= '{vin_ok: 1'b1, input_turn_on_threshold: 1'b1, input_turn_off_threshold: 1'b0, rails_20: 1'b1, dig_7: 1'b1};
    settle();
    `CHK(alert_oe, 1'b1)
    rd(REG_STATUS, d);
    `CHK(d[COMMON_NVM_UNINIT], 1'b1)
    slfs_host_model_i.peer_fault_pull <= 1'b0;
    repeat (20) @(posedge mclk);
    `CHK(switch_en, 1'b0)
    wr(REG_CTRL, 32'h0000_000b);
    wr(REG_BUS_CMD, 32'h0);
    wait_sw(1'b1);
    `CHK(power_good_oe, 1'b0)
    count_oe(250);
    `CHK(hs, 16'd25)
    `CHK(hy, 16'd65)
    `CHK({fault_line_out, sync_out, share_clk_out, power_good_out, run_out, alert_out}, 6'h00)
    $display("test power done");
    telemetry <= 16'h1234;
    settle();
    telemetry <= 16'h0100;
    rd(REG_PEAK, d);
    `CHK(d[15:0], 16'h1234)
    die_temp_c <= 8'h56;
    settle();
    `CHK(nvm_warm, 1'b1)
    die_temp_c <= 8'h83;
    settle();
    `CHK(nvm_en, 1'b0)
    die_temp_c <= 8'h7d;
    settle();
    `CHK(nvm_en, 1'b0)
    die_temp_c <= 8'h77;
    settle();
    `CHK(nvm_en, 1'b1)
    $display("test peak temp done");
    supply <= '{vin_ok: 1'b1, input_turn_on_threshold: 1'b0, input_turn_off_threshold: 1'b1, rails_20: 1'b1, dig_7: 1'b1};
    settle();
    count_oe(20);
    `CHK(hs, 16'd20)
    `CHK(switch_en, 1'b0)
    supply.input_turn_off_threshold <= 1'b0;
    count_oe(20);
    `CHK(hs, 16'd20)
    supply.input_turn_on_threshold <= 1'b1;
    wait_sw(1'b1);
    count_oe(250);
    `CHK(hs, 16'd25)
    $display("test input band done");
    wr(REG_FAULT_CFG, 32'h10);
    wr(REG_RESPONSE, 32'h100);
    telemetry <= 16'h0777;
    faults.uv <= 1'b1;
    settle();
    `CHK(switch_en, 1'b0)
    `CHK(fault_line_oe, 1'b1)
    `CHK(power_good_oe, 1'b1)
    faults.uv <= 1'b0;
    repeat (10) @(posedge mclk);
    rd(REG_STATUS, d);
    `CHK(d[11:7], 5'h08)
    rd(REG_LOG, d);
    `CHK(d[15:0], 16'h0777)
    faults.ov <= 1'b1;
    settle();
    `CHK(gate, 2'h1)
    faults.ov <= 1'b0;
    $display("test latch done");
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    wr(REG_BUS_CMD, 32'h0);
    wait_sw(1'b1);
    wr(REG_RETRY, 32'h14);
    wr(REG_RESPONSE, 32'h200);
    faults.uv <= 1'b1;
    @(posedge mclk);
    faults.uv <= 1'b0;
    rd(REG_STATUS, d);
    `CHK(d[11:7], 5'h10)
    wait_sw(1'b1);
    wr(REG_RESPONSE, 32'h0);
    faults.uv <= 1'b1;
    repeat (10) @(posedge mclk);
    `CHK(switch_en, 1'b1)
    faults.uv <= 1'b0;
    $display("test retry done");
    conclude();
  end
endmodule
